// ==== verilog/fsc_pkg.sv ====
//------------------------------------------------------------------------------
// Purpose: shared constants for the fifo strap configuration and flag block
// Assumes: one clock (pclk, 25 MHz), apb register access, 36-bit data words
// Notes: offsets are byte addresses, one aligned 32-bit word per register
//------------------------------------------------------------------------------
// Overview of operation
// - byte order strap latched at master reset; low big-endian, high little-endian.
// - write bus is 36, 18 or 9 bits; unused data lines ignored.
// - standard timing: shared empty/ready output shows storage holds no words.
// - fall-through timing: shared empty/ready output shows valid word presented.
// - standard timing: shared full/ready output shows no room for a write word.
// - fall-through timing: shared full/ready output shows room for a write.
// - offset selects plus load pin pick one of eight default offsets.
// - lookahead pin sampled at master reset picks fall-through or standard.
// - after master reset lookahead pin is only the serial offset input.
// - half-full output shows stored words above or below half capacity.
// - parity position strap latched at reset; low non-interspersed, high interspersed.
// - parity position affects parallel offset loads only, never data words.
// - write width set from write, read width and width-match straps.
// - load pin at master reset picks serial or parallel offset programming.
// - after reset load pin steers parallel-mode writes to offset registers and blocks reads.
// - almost-empty low below empty offset; almost-full low when free <= offset.
// - interspersed: bits 8,17,26,35 parity; else 8,17,26 valid, 32-35 ignored.
package fsc_pkg;
  localparam int DEPTH_DEF = 1024;
  localparam int DW = 36;
  localparam int OFS_W = 16;
  localparam int AW = 8;

  // storage is counted in 9-bit units so narrow ports stay exact
  localparam logic [2:0] U36 = 3'h4;
  localparam logic [2:0] U18 = 3'h2;
  localparam logic [2:0] U9 = 3'h1;
  localparam int UNIT_SHIFT = 2;
  localparam logic [35:0] MASK_36 = 36'hf_ffff_ffff;
  localparam logic [35:0] MASK_18 = 36'h0_0003_ffff;
  localparam logic [35:0] MASK_9 = 36'h0_0000_01ff;

  // default offsets indexed by {load pin, sel_1, sel_0}
  localparam logic [OFS_W-1:0] DEF_OFS [8] = '{
    16'h007f, 16'h00ff, 16'h01ff, 16'h03ff,
    16'h0007, 16'h000f, 16'h001f, 16'h003f
  };

  // register map
  localparam logic [AW-1:0] A_CFG = 8'h00;
  localparam logic [AW-1:0] A_STATUS = 8'h04;
  localparam logic [AW-1:0] A_COUNT = 8'h08;
  localparam logic [AW-1:0] A_EOFS = 8'h0c;
  localparam logic [AW-1:0] A_FOFS = 8'h10;

  // cfg register fields
  localparam int CFG_FWFT = 0;
  localparam int CFG_BE = 1;
  localparam int CFG_IP = 2;
  localparam int CFG_SER = 3;
  localparam int CFG_BM = 4;
  localparam int CFG_IW = 5;
  localparam int CFG_OW = 6;
  localparam int CFG_SEL = 7;

  // status register fields
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_HF = 2;
  localparam int ST_AE = 3;
  localparam int ST_AF = 4;
  localparam int ST_MRS = 5;

  // synchroniser lane order
  localparam int P_MRS = 0;
  localparam int P_SEN = 1;
  localparam int P_LD = 2;
  localparam int P_SEL0 = 3;
  localparam int P_SEL1 = 4;
  localparam int P_SI = 5;
  localparam int P_IP = 6;
  localparam int P_BE = 7;
  localparam int P_OW = 8;
  localparam int P_IW = 9;
  localparam int P_BM = 10;
  localparam int NPIN = 11;
  // active-low pins idle high; master reset held active until seen
  localparam logic [NPIN-1:0] PIN_RST = 11'h006;
endpackage : fsc_pkg

// ==== verilog/fsc_sync.sv ====
//------------------------------------------------------------------------------
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: each lane is an independent level
// Notes: first stage feeds only the second stage
//------------------------------------------------------------------------------
module fsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule : fsc_sync

// ==== verilog/fsc_ofs_extract.sv ====
//------------------------------------------------------------------------------
// Purpose: strip parity positions from a parallel offset load word
// Assumes: data already masked to the configured write width
// Notes: purely combinational, used only on the offset load path
//------------------------------------------------------------------------------
module fsc_ofs_extract (
  input wire logic [35:0] din,
  input wire logic interspersed,
  output logic [31:0] ofs
);
  always_comb begin
    if (interspersed) begin
      ofs = {din[34:27], din[25:18], din[16:9], din[7:0]};
    end else begin
      ofs = din[31:0];
    end
  end
endmodule : fsc_ofs_extract

// ==== verilog/fsc_top.sv ====
//------------------------------------------------------------------------------
// Purpose: strap capture, width decode, offset registers and status flags
// Assumes: producer and consumer strobes are on pclk; straps and pins are not
// Notes: flags are registered from the next-state count, so they track the
//        count register exactly; pins lag two cycles through the synchroniser
//------------------------------------------------------------------------------
module fsc_top #(
  parameter int DEPTH = fsc_pkg::DEPTH_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fsc_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic master_reset_n,
  input wire logic width_match_strap,
  input wire logic write_width_strap,
  input wire logic read_width_strap,
  input wire logic byte_order_strap,
  input wire logic parity_position_strap,
  input wire logic lookahead_strap_serial_load,
  input wire logic default_offset_sel_0,
  input wire logic default_offset_sel_1,
  input wire logic offset_access_enable_n,
  input wire logic serial_shift_en_n,
  input wire logic wr_en,
  input wire logic [fsc_pkg::DW-1:0] wr_data,
  input wire logic rd_en,
  output logic empty_flag,
  output logic full_flag,
  output logic half_full_flag_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n
);
  localparam int CAP = DEPTH * 4;
  localparam int UW = $clog2(CAP) + 1;
  localparam logic [UW-1:0] CAP_U = UW'(CAP);

  //----------------------------------------------------------------------------
  // pin synchronisers
  //----------------------------------------------------------------------------
  logic [fsc_pkg::NPIN-1:0] pins;
  logic [fsc_pkg::NPIN-1:0] sp;

  assign pins = {width_match_strap, write_width_strap, read_width_strap,
                 byte_order_strap, parity_position_strap,
                 lookahead_strap_serial_load, default_offset_sel_1,
                 default_offset_sel_0, offset_access_enable_n,
                 serial_shift_en_n, master_reset_n};

  fsc_sync #(
    .W(fsc_pkg::NPIN),
    .RST_VAL(fsc_pkg::PIN_RST)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pins),
    .q(sp)
  );

  logic master_reset;
  logic ld_n;
  logic sen_n;
  logic si;
  logic [2:0] def_idx;

  assign master_reset = !sp[fsc_pkg::P_MRS];
  assign ld_n = sp[fsc_pkg::P_LD];
  assign sen_n = sp[fsc_pkg::P_SEN];
  assign si = sp[fsc_pkg::P_SI];
  assign def_idx = {sp[fsc_pkg::P_LD], sp[fsc_pkg::P_SEL1], sp[fsc_pkg::P_SEL0]};

  //----------------------------------------------------------------------------
  // configuration capture
  //----------------------------------------------------------------------------
  // straps are expected stable after release, so no check is made on them
  logic fwft_reg, fwft_next;
  logic be_reg, be_next;
  logic ip_reg, ip_next;
  logic ser_reg, ser_next;
  logic bm_reg, bm_next;
  logic iw_reg, iw_next;
  logic ow_reg, ow_next;
  logic [2:0] sel_reg, sel_next;

  always_comb begin
    fwft_next = fwft_reg;
    be_next = be_reg;
    ip_next = ip_reg;
    ser_next = ser_reg;
    bm_next = bm_reg;
    iw_next = iw_reg;
    ow_next = ow_reg;
    sel_next = sel_reg;
    if (master_reset) begin
      fwft_next = si;
      be_next = sp[fsc_pkg::P_BE];
      ip_next = sp[fsc_pkg::P_IP];
      ser_next = !ld_n;
      bm_next = sp[fsc_pkg::P_BM];
      iw_next = sp[fsc_pkg::P_IW];
      ow_next = sp[fsc_pkg::P_OW];
      sel_next = def_idx;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwft_reg <= 1'b0;
      be_reg <= 1'b0;
      ip_reg <= 1'b0;
      ser_reg <= 1'b0;
      bm_reg <= 1'b0;
      iw_reg <= 1'b0;
      ow_reg <= 1'b0;
      sel_reg <= 3'h0;
    end else begin
      fwft_reg <= fwft_next;
      be_reg <= be_next;
      ip_reg <= ip_next;
      ser_reg <= ser_next;
      bm_reg <= bm_next;
      iw_reg <= iw_next;
      ow_reg <= ow_next;
      sel_reg <= sel_next;
    end
  end

  //----------------------------------------------------------------------------
  // port width decode
  //----------------------------------------------------------------------------
  logic [2:0] wunits;
  logic [2:0] runits;
  logic [35:0] wmask;

  always_comb begin
    wunits = fsc_pkg::U36;
    runits = fsc_pkg::U36;
    if (bm_reg && !iw_reg) begin
      runits = ow_reg ? fsc_pkg::U9 : fsc_pkg::U18;
    end else if (bm_reg) begin
      wunits = ow_reg ? fsc_pkg::U9 : fsc_pkg::U18;
    end
    if (wunits == fsc_pkg::U9) begin
      wmask = fsc_pkg::MASK_9;
    end else if (wunits == fsc_pkg::U18) begin
      wmask = fsc_pkg::MASK_18;
    end else begin
      wmask = fsc_pkg::MASK_36;
    end
  end

  logic [31:0] ext_ofs;

  // parity handling lives only on the offset path; stored words never see it
  fsc_ofs_extract u_ext (
    .din(wr_data & wmask),
    .interspersed(ip_reg),
    .ofs(ext_ofs)
  );

  //----------------------------------------------------------------------------
  // occupancy and offset registers
  //----------------------------------------------------------------------------
  logic [UW-1:0] count_reg, count_next;
  logic [fsc_pkg::OFS_W-1:0] eofs_reg, eofs_next;
  logic [fsc_pkg::OFS_W-1:0] fofs_reg, fofs_next;
  logic ld_sel_reg, ld_sel_next;
  logic [UW-1:0] free_u;
  logic wr_ok;
  logic rd_ok;
  logic ofs_wr;
  logic ser_sh;
  logic apb_wr;

  assign free_u = CAP_U - count_reg;
  assign wr_ok = wr_en && ld_n && !master_reset && (free_u >= UW'(wunits));
  assign rd_ok = rd_en && ld_n && !master_reset && (count_reg >= UW'(runits));
  assign ofs_wr = wr_en && !ld_n && !master_reset && !ser_reg;
  assign ser_sh = !sen_n && !ld_n && !master_reset && ser_reg;
  assign apb_wr = psel && penable && pwrite && pready;

  always_comb begin
    count_next = count_reg;
    eofs_next = eofs_reg;
    fofs_next = fofs_reg;
    ld_sel_next = ld_sel_reg;
    if (master_reset) begin
      count_next = '0;
      eofs_next = fsc_pkg::DEF_OFS[def_idx];
      fofs_next = fsc_pkg::DEF_OFS[def_idx];
      ld_sel_next = 1'b0;
    end else begin
      count_next = count_reg + (wr_ok ? UW'(wunits) : '0) - (rd_ok ? UW'(runits) : '0);
      if (apb_wr && paddr == fsc_pkg::A_EOFS) begin
        eofs_next = pwdata[fsc_pkg::OFS_W-1:0];
      end else if (apb_wr && paddr == fsc_pkg::A_FOFS) begin
        fofs_next = pwdata[fsc_pkg::OFS_W-1:0];
      end else if (ofs_wr) begin
        // empty offset first, then full offset, alternating
        if (ld_sel_reg) begin
          fofs_next = ext_ofs[fsc_pkg::OFS_W-1:0];
        end else begin
          eofs_next = ext_ofs[fsc_pkg::OFS_W-1:0];
        end
        ld_sel_next = !ld_sel_reg;
      end else if (ser_sh) begin
        {fofs_next, eofs_next} = {fofs_reg[fsc_pkg::OFS_W-2:0], eofs_reg, si};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      eofs_reg <= fsc_pkg::DEF_OFS[0];
      fofs_reg <= fsc_pkg::DEF_OFS[0];
      ld_sel_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      eofs_reg <= eofs_next;
      fofs_reg <= fofs_next;
      ld_sel_reg <= ld_sel_next;
    end
  end

  //----------------------------------------------------------------------------
  // status flags
  //----------------------------------------------------------------------------
  logic ef_reg, ef_next;
  logic ff_reg, ff_next;
  logic hf_reg, hf_next;
  logic ae_reg, ae_next;
  logic af_reg, af_next;
  logic [31:0] words_n;
  logic [31:0] free_words_n;
  logic [UW-1:0] free_next;

  always_comb begin
    free_next = CAP_U - count_next;
    words_n = 32'(count_next >> fsc_pkg::UNIT_SHIFT);
    free_words_n = 32'(free_next >> fsc_pkg::UNIT_SHIFT);
    if (fwft_reg) begin
      ef_next = !(count_next >= UW'(runits));
      ff_next = !(free_next >= UW'(wunits));
    end else begin
      ef_next = (count_next != '0);
      ff_next = (free_next >= UW'(wunits));
    end
    hf_next = !(words_n > 32'(DEPTH / 2));
    ae_next = (words_n >= 32'(eofs_next));
    af_next = (free_words_n > 32'(fofs_next));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ef_reg <= 1'b0;
      ff_reg <= 1'b1;
      hf_reg <= 1'b1;
      ae_reg <= 1'b0;
      af_reg <= 1'b1;
    end else begin
      ef_reg <= ef_next;
      ff_reg <= ff_next;
      hf_reg <= hf_next;
      ae_reg <= ae_next;
      af_reg <= af_next;
    end
  end

  assign empty_flag = ef_reg;
  assign full_flag = ff_reg;
  assign half_full_flag_n = hf_reg;
  assign almost_empty_flag_n = ae_reg;
  assign almost_full_flag_n = af_reg;

  //----------------------------------------------------------------------------
  // apb slave
  //----------------------------------------------------------------------------
  // zero wait states: answer prepared in setup, presented in access
  logic pready_reg, pready_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] cfg_word;
  logic [31:0] st_word;

  always_comb begin
    cfg_word = '0;
    cfg_word[fsc_pkg::CFG_FWFT] = fwft_reg;
    cfg_word[fsc_pkg::CFG_BE] = be_reg;
    cfg_word[fsc_pkg::CFG_IP] = ip_reg;
    cfg_word[fsc_pkg::CFG_SER] = ser_reg;
    cfg_word[fsc_pkg::CFG_BM] = bm_reg;
    cfg_word[fsc_pkg::CFG_IW] = iw_reg;
    cfg_word[fsc_pkg::CFG_OW] = ow_reg;
    cfg_word[fsc_pkg::CFG_SEL +: 3] = sel_reg;
    st_word = '0;
    st_word[fsc_pkg::ST_EMPTY] = ef_reg;
    st_word[fsc_pkg::ST_FULL] = ff_reg;
    st_word[fsc_pkg::ST_HF] = hf_reg;
    st_word[fsc_pkg::ST_AE] = ae_reg;
    st_word[fsc_pkg::ST_AF] = af_reg;
    st_word[fsc_pkg::ST_MRS] = master_reset;
  end

  always_comb begin
    pready_next = psel && !penable;
    prdata_next = '0;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      if (paddr == fsc_pkg::A_CFG) begin
        prdata_next = cfg_word;
      end else if (paddr == fsc_pkg::A_STATUS) begin
        prdata_next = st_word;
      end else if (paddr == fsc_pkg::A_COUNT) begin
        prdata_next = 32'(count_reg);
      end else if (paddr == fsc_pkg::A_EOFS) begin
        prdata_next = 32'(eofs_reg);
      end else if (paddr == fsc_pkg::A_FOFS) begin
        prdata_next = 32'(fofs_reg);
      end else begin
        pslverr_next = 1'b1;
      end
      if (pwrite) begin
        prdata_next = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_mrs_release;
    master_reset ##1 !master_reset;
  endsequence

  property p_cfg_hold;
    s_mrs_release ##1 !master_reset |-> $stable({fwft_reg, be_reg, ip_reg, ser_reg, bm_reg,
                                         iw_reg, ow_reg, sel_reg});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved outside reset");

  property p_fwft_cap;
    master_reset |=> fwft_reg == $past(si);
  endproperty
  a_fwft_cap: assert property (p_fwft_cap) else $error("timing mode not captured");

  property p_be_cap;
    master_reset |=> be_reg == $past(sp[fsc_pkg::P_BE]);
  endproperty
  a_be_cap: assert property (p_be_cap) else $error("byte order not captured");

  property p_ip_cap;
    master_reset |=> ip_reg == $past(sp[fsc_pkg::P_IP]) && ser_reg == !$past(ld_n);
  endproperty
  a_ip_cap: assert property (p_ip_cap) else $error("parity or load method lost");

  property p_ef_std;
    !$past(fwft_reg) |-> ef_reg == (count_reg != '0);
  endproperty
  a_ef_std: assert property (p_ef_std) else $error("empty flag wrong");

  property p_ff_fwft;
    $past(fwft_reg) |-> ff_reg == (free_u < UW'($past(wunits)));
  endproperty
  a_ff_fwft: assert property (p_ff_fwft) else $error("input ready wrong");

  property p_hf;
    hf_reg == !(32'(count_reg >> fsc_pkg::UNIT_SHIFT) > 32'(DEPTH / 2));
  endproperty
  a_hf: assert property (p_hf) else $error("half full flag wrong");

  property p_ae;
    ae_reg == (32'(count_reg >> fsc_pkg::UNIT_SHIFT) >= 32'(eofs_reg));
  endproperty
  a_ae: assert property (p_ae) else $error("almost empty flag wrong");

  property p_wr_count;
    wr_ok && !rd_ok |=> count_reg == $past(count_reg) + UW'($past(wunits));
  endproperty
  a_wr_count: assert property (p_wr_count) else $error("write width count wrong");

  property p_ld_steer;
    !ld_n && !master_reset |=> count_reg == $past(count_reg);
  endproperty
  a_ld_steer: assert property (p_ld_steer) else $error("load pin reached storage");

  property p_serial;
    ser_sh && !apb_wr |=> eofs_reg[0] == $past(si);
  endproperty
  a_serial: assert property (p_serial) else $error("serial bit not shifted");

  property p_par_load;
    ofs_wr && !apb_wr && !ld_sel_reg |=> eofs_reg == $past(ext_ofs[fsc_pkg::OFS_W-1:0]);
  endproperty
  a_par_load: assert property (p_par_load) else $error("parallel offset wrong");
endmodule : fsc_top

// ==== tb/fsc_fifo_partner.sv ====
//------------------------------------------------------------------------------
// Purpose: producer and consumer model on the write and read strobe ports
// Assumes: one strobe cycle per call, launched just after a rising edge
// Notes: idle data lines show the inverse word, never a stale copy
//------------------------------------------------------------------------------
module fsc_fifo_partner (
  input wire logic pclk,
  output logic wr_en,
  output logic [35:0] wr_data,
  output logic rd_en
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_data = 36'h0_0000_0000;
  end

  // ----------------------------------------------------------------------------
  // strobe task
  // ----------------------------------------------------------------------------
  task automatic strobe(input logic w, input logic r, input logic [35:0] d);
    @(posedge pclk);
    wr_en <= w;
    rd_en <= r;
    wr_data <= d;
    @(posedge pclk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    wr_data <= ~d;
  endtask : strobe
endmodule : fsc_fifo_partner

// ==== tb/fsc_top_tb_top.sv ====
//------------------------------------------------------------------------------
// Purpose: apb and strobe level test of strap capture and status flags
// Assumes: DEPTH 16 so a full fill stays short
// Notes: flags read one step after the taking edge so its updates land
//------------------------------------------------------------------------------
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fail_count++; \
  $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module fsc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, wr_en, rd_en;
  logic [31:0] prdata;
  logic [35:0] wr_data;
  logic mrst_n = 1'b1;
  logic sen_n = 1'b1;
  // bm iw ow be ip lookahead sel0 sel1 load_n
  logic [8:0] strap = 9'h100;
  logic empty_flag, full_flag, half_full_flag_n, almost_empty_flag_n, almost_full_flag_n;
  int fail_count = 0;
  int n_compared = 0;
  logic [31:0] d;
  logic e;
  logic [2:0] md [5] = '{3'h0, 3'h1, 3'h5, 3'h3, 3'h7};
  int wu [5] = '{4, 4, 4, 2, 1};
  int ru [5] = '{4, 2, 1, 4, 4};

  always #20 pclk = ~pclk;

  fsc_top #(.DEPTH(DEPTH)) i_fsc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .master_reset_n(mrst_n),
    .width_match_strap(strap[0]), .write_width_strap(strap[1]), .read_width_strap(strap[2]),
    .byte_order_strap(strap[3]), .parity_position_strap(strap[4]),
    .lookahead_strap_serial_load(strap[5]), .default_offset_sel_0(strap[6]),
    .default_offset_sel_1(strap[7]), .offset_access_enable_n(strap[8]),
    .serial_shift_en_n(sen_n), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
    .empty_flag(empty_flag), .full_flag(full_flag), .half_full_flag_n(half_full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n));
  fsc_fifo_partner i_fsc_fifo_partner (.pclk(pclk), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en));

  // ----------------------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      print_verdict();
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] ex, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK("pslverr", ee, e)
    if (!ee) `CHK("prdata", ex, d)
  endtask : reg_chk

  // straps held across master reset; load and serial pins reused after it
  task automatic mreset(input logic [8:0] s);
    @(posedge pclk);
    strap <= s;
    mrst_n <= 1'b0;
    repeat (5) @(posedge pclk);
    mrst_n <= 1'b1;
    repeat (5) @(posedge pclk);
    strap[8] <= 1'b1;
    strap[5] <= 1'b1;
  endtask : mreset

  // standard mode, empty offset 4, full offset 3
  task automatic flags(input int k);
    #1;
    `CHK("empty", k != 0, empty_flag)
    `CHK("full", k != DEPTH, full_flag)
    `CHK("half", !(k > DEPTH / 2), half_full_flag_n)
    `CHK("aempty", !(k < 4), almost_empty_flag_n)
    `CHK("afull", !(DEPTH - k <= 3), almost_full_flag_n)
    reg_chk(8'h08, 4 * k, 1'b0);
  endtask : flags

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    mreset(9'h158);
    reg_chk(8'h00, 32'h0000_0286, 1'b0);
    reg_chk(8'h0c, 32'h0000_000f, 1'b0);
    flags(0);
    // straps moved on purpose; captured copy must not follow
    strap[3] <= 1'b0;
    strap[7] <= 1'b1;
    apb(1'b1, 8'h00, 32'hffff_ffff);
    reg_chk(8'h00, 32'h0000_0286, 1'b0);
    reg_chk(8'h14, 32'h0, 1'b1);
    apb(1'b1, 8'h0c, 32'h0000_0004);
    apb(1'b1, 8'h10, 32'h0000_0003);
    reg_chk(8'h10, 32'h0000_0003, 1'b0);
    for (int i = 1; i <= DEPTH + 1; i++) begin
      i_fsc_fifo_partner.strobe(1'b1, 1'b0, 36'h5_a5a5_a5a5);
      flags(i > DEPTH ? DEPTH : i);
    end
    for (int i = DEPTH - 1; i >= -1; i--) begin
      i_fsc_fifo_partner.strobe(1'b0, 1'b1, 36'h0_0000_0000);
      flags(i < 0 ? 0 : i);
    end
    // parallel loads with interspersed parity: bit 8 dropped, storage untouched
    @(posedge pclk);
    strap[8] <= 1'b0;
    repeat (3) @(posedge pclk);
    i_fsc_fifo_partner.strobe(1'b1, 1'b0, 36'h0_0000_2534);
    reg_chk(8'h0c, 32'h0000_1234, 1'b0);
    i_fsc_fifo_partner.strobe(1'b1, 1'b0, 36'h0_0000_2534);
    reg_chk(8'h10, 32'h0000_1234, 1'b0);
    reg_chk(8'h08, 32'h0, 1'b0);
    @(posedge pclk);
    strap[8] <= 1'b1;
    repeat (3) @(posedge pclk);
    // fall-through, serial programming, every width pairing
    for (int m = 0; m < 5; m++) begin
      mreset({6'h04, md[m]});
      reg_chk(8'h00, 32'h9 | (md[m] << 4), 1'b0);
      #1;
      `CHK("ready_out", 1'b1, empty_flag)
      `CHK("room_in", 1'b0, full_flag)
      i_fsc_fifo_partner.strobe(1'b1, 1'b0, 36'hf_ffff_fe01);
      reg_chk(8'h08, wu[m], 1'b0);
      #1;
      `CHK("ready_out", !(wu[m] >= ru[m]), empty_flag)
    end
    // serial shift of sixteen ones into the empty offset
    @(posedge pclk);
    strap[8] <= 1'b0;
    sen_n <= 1'b0;
    repeat (16) @(posedge pclk);
    strap[8] <= 1'b1;
    sen_n <= 1'b1;
    repeat (4) @(posedge pclk);
    reg_chk(8'h0c, 32'h0000_ffff, 1'b0);
    reg_chk(8'h10, 32'h0000_007f, 1'b0);
    print_verdict();
  end
endmodule : fsc_top_tb_top
